// file: design/kpi_pkg.sv
package kpi_pkg;

  // ------------------------------------------------------------
  // Register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] KPI_ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] KPI_ADDR_PIN_ENABLE = 8'h04;
  localparam logic [7:0] KPI_ADDR_EDGE_POLARITY = 8'h08;
  localparam logic [7:0] KPI_ADDR_EVENT_STATUS = 8'h0c;
  localparam logic [7:0] KPI_ADDR_EVENT_MASK = 8'h10;

  // ------------------------------------------------------------
  // Status and control field positions
  // ------------------------------------------------------------
  localparam int KPI_BIT_DETECT_MODE = 0;
  localparam int KPI_BIT_IRQ_ENABLE = 1;
  localparam int KPI_BIT_IRQ_ACK = 2;
  localparam int KPI_BIT_IRQ_FLAG = 3;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] KPI_RST_PIN_ENABLE = 8'h00;
  localparam logic [7:0] KPI_RST_EDGE_POLARITY = 8'h00;
  localparam logic [7:0] KPI_RST_EVENT_MASK = 8'h00;
  localparam logic KPI_RST_DETECT_MODE = 1'h0;
  localparam logic KPI_RST_IRQ_ENABLE = 1'h0;

  // ------------------------------------------------------------
  // Bus responses, timing and pin limit
  // ------------------------------------------------------------
  localparam logic [1:0] KPI_RESP_OKAY = 2'h0;
  localparam logic [1:0] KPI_RESP_SLVERR = 2'h2;
  localparam int KPI_SYNC_STAGES = 3;
  localparam int KPI_MAX_PINS = 8;

endpackage

// file: design/kpi_keypad_pin_interrupt.sv
`timescale 1ns/1ps

module kpi_keypad_pin_interrupt
  import kpi_pkg::*;
#(
  parameter int PIN_COUNT = 8
) (
  input wire logic refClk,
  input wire logic rst,
  input wire logic [PIN_COUNT-1:0] pinIn,
  input wire logic [PIN_COUNT-1:0] pullEnable,
  output logic [PIN_COUNT-1:0] pullUpOn,
  output logic [PIN_COUNT-1:0] pullDownOn,
  output logic pinIrqRequest,
  output logic irqOut,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  if (PIN_COUNT < 1 || PIN_COUNT > KPI_MAX_PINS) begin : gBadCount
    $error("PIN_COUNT must lie between 1 and 8");
  end

  // All control fields share byte 0, the lane that wstrb[0] guards
  if (KPI_BIT_DETECT_MODE > 7 || KPI_BIT_IRQ_ENABLE > 7
      || KPI_BIT_IRQ_ACK > 7 || KPI_BIT_IRQ_FLAG > 7) begin : gBadField
    $error("Control fields must lie in byte 0");
  end

  // The chain below is built with a fixed three stages
  if (KPI_SYNC_STAGES != 3) begin : gBadSync
    $error("Pin synchroniser depth must be three");
  end

  // Decode compares all 8 address bits; registers must still sit on word boundaries
  if (KPI_ADDR_STATUS_CONTROL[1:0] != 2'h0
      || KPI_ADDR_PIN_ENABLE[1:0] != 2'h0
      || KPI_ADDR_EDGE_POLARITY[1:0] != 2'h0
      || KPI_ADDR_EVENT_STATUS[1:0] != 2'h0
      || KPI_ADDR_EVENT_MASK[1:0] != 2'h0) begin : gBadAddr
    $error("Register addresses must be word aligned");
  end

  // Reset values are cut to the pin count; lost set bits are refused
  if ((KPI_RST_PIN_ENABLE >> PIN_COUNT) != 8'h00
      || (KPI_RST_EDGE_POLARITY >> PIN_COUNT) != 8'h00
      || (KPI_RST_EVENT_MASK >> PIN_COUNT) != 8'h00) begin : gBadReset
    $error("Reset values exceed the pin count");
  end

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [PIN_COUNT-1:0] pinEnable_q;
  logic [PIN_COUNT-1:0] polarity_q;
  logic [PIN_COUNT-1:0] eventMask_q;
  logic [PIN_COUNT-1:0] eventStatus_q;
  logic [PIN_COUNT-1:0] eventStatus_d;
  logic detectMode_q;
  logic irqEnable_q;
  logic irqFlag_q;
  logic irqFlag_d;

  // ------------------------------------------------------------
  // Pin synchronisers and qualified level
  // ------------------------------------------------------------
  logic [PIN_COUNT-1:0] sync1_q;
  logic [PIN_COUNT-1:0] sync2_q;
  logic [PIN_COUNT-1:0] sync3_q;
  logic [PIN_COUNT-1:0] pinLevel_q;
  logic [PIN_COUNT-1:0] wasDeasserted_q;
  logic [PIN_COUNT-1:0] asserted;
  logic [PIN_COUNT-1:0] edgeHit;
  logic [PIN_COUNT-1:0] levelHit;

  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Level only moves once the last two stages agree, so a pin
  // caught mid-transition cannot fake a one-cycle edge.
  genvar gi;
  for (gi = 0; gi < PIN_COUNT; gi++) begin : gPin
    always_ff @(posedge refClk or posedge rst) begin
      if (rst) begin
        pinLevel_q[gi] <= 1'h0;
      end else if (sync2_q[gi] == sync3_q[gi]) begin
        pinLevel_q[gi] <= sync3_q[gi];
      end
    end

    // Polarity 0: low asserts; polarity 1: high asserts
    assign asserted[gi] = pinLevel_q[gi] ^ ~polarity_q[gi];
    assign levelHit[gi] = pinEnable_q[gi] & asserted[gi];
    // Previous cycle deasserted, this cycle asserted
    assign edgeHit[gi] = levelHit[gi] & wasDeasserted_q[gi];

    always_ff @(posedge refClk or posedge rst) begin
      if (rst) begin
        wasDeasserted_q[gi] <= 1'h0;
      end else begin
        // Cleared while disabled: a pin just enabled must first
        // be seen deasserted before any edge counts
        // Level mode still flags an already-asserted pin on
        // enabling, hence the acknowledge after setup
        wasDeasserted_q[gi] <= pinEnable_q[gi] & ~asserted[gi];
      end
    end

    // Pull choice follows polarity even while the pin is disabled
    assign pullUpOn[gi] = pullEnable[gi] & ~polarity_q[gi];
    assign pullDownOn[gi] = pullEnable[gi] & polarity_q[gi];
  end

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  logic awHeld_q;
  logic wHeld_q;
  logic [7:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bValid_q;
  logic [1:0] bResp_q;

  // One write at a time: a response not yet taken stalls the next
  wire doWrite = awHeld_q & wHeld_q & ~bValid_q;
  wire wrLane0 = doWrite & wStrb_q[0];
  wire wrMapped = (awAddr_q == KPI_ADDR_STATUS_CONTROL)
                | (awAddr_q == KPI_ADDR_PIN_ENABLE)
                | (awAddr_q == KPI_ADDR_EDGE_POLARITY)
                | (awAddr_q == KPI_ADDR_EVENT_STATUS)
                | (awAddr_q == KPI_ADDR_EVENT_MASK);
  wire wrCtrl = wrLane0 & (awAddr_q == KPI_ADDR_STATUS_CONTROL);
  wire wrEnable = wrLane0 & (awAddr_q == KPI_ADDR_PIN_ENABLE);
  wire wrPolarity = wrLane0 & (awAddr_q == KPI_ADDR_EDGE_POLARITY);
  // Event status is read-only: a write is answered and dropped
  wire wrMask = wrLane0 & (awAddr_q == KPI_ADDR_EVENT_MASK);
  wire ackWrite = wrCtrl & wData_q[KPI_BIT_IRQ_ACK];

  assign s_axi_awready = ~awHeld_q;
  assign s_axi_wready = ~wHeld_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;

  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'h0;
      awAddr_q <= '0;
    end else if (s_axi_awvalid & ~awHeld_q) begin
      awHeld_q <= 1'h1;
      awAddr_q <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_q <= 1'h0;
    end
  end

  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      wHeld_q <= 1'h0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else if (s_axi_wvalid & ~wHeld_q) begin
      wHeld_q <= 1'h1;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_q <= 1'h0;
    end
  end

  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      bValid_q <= 1'h0;
      bResp_q <= KPI_RESP_OKAY;
    end else if (doWrite) begin
      bValid_q <= 1'h1;
      bResp_q <= wrMapped ? KPI_RESP_OKAY : KPI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_q <= 1'h0;
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      detectMode_q <= KPI_RST_DETECT_MODE;
      irqEnable_q <= KPI_RST_IRQ_ENABLE;
    end else if (wrCtrl) begin
      detectMode_q <= wData_q[KPI_BIT_DETECT_MODE];
      irqEnable_q <= wData_q[KPI_BIT_IRQ_ENABLE];
    end
  end

  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      pinEnable_q <= KPI_RST_PIN_ENABLE[PIN_COUNT-1:0];
      polarity_q <= KPI_RST_EDGE_POLARITY[PIN_COUNT-1:0];
      eventMask_q <= KPI_RST_EVENT_MASK[PIN_COUNT-1:0];
    end else begin
      if (wrEnable) begin
        pinEnable_q <= wData_q[PIN_COUNT-1:0];
      end
      if (wrPolarity) begin
        polarity_q <= wData_q[PIN_COUNT-1:0];
      end
      if (wrMask) begin
        eventMask_q <= wData_q[PIN_COUNT-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt flag
  // ------------------------------------------------------------
  wire anyEdge = |edgeHit;
  wire anyLevel = |levelHit;
  wire levelSet = detectMode_q & anyLevel;
  wire flagSet = anyEdge | levelSet;
  // Level mode refuses the clear while any enabled pin asserts
  wire flagClear = ackWrite & (~detectMode_q | ~anyLevel);

  // Set beats clear; the flag bit of the written data is ignored
  always_comb begin
    irqFlag_d = irqFlag_q;
    if (flagClear) begin
      irqFlag_d = 1'h0;
    end
    if (flagSet) begin
      irqFlag_d = 1'h1;
    end
  end

  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      irqFlag_q <= 1'h0;
    end else begin
      irqFlag_q <= irqFlag_d;
    end
  end

  assign pinIrqRequest = irqFlag_q & irqEnable_q;

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  logic rValid_q;
  logic [31:0] rData_q;
  logic [1:0] rResp_q;
  logic [31:0] rdMux;
  logic [31:0] ctrlWord;
  logic [31:0] enableWord;
  logic [31:0] polarityWord;
  logic [31:0] statusWord;
  logic [31:0] maskWord;

  wire doRead = s_axi_arvalid & ~rValid_q;
  wire rdSelCtrl = s_axi_araddr == KPI_ADDR_STATUS_CONTROL;
  wire rdSelEnable = s_axi_araddr == KPI_ADDR_PIN_ENABLE;
  wire rdSelPolarity = s_axi_araddr == KPI_ADDR_EDGE_POLARITY;
  wire rdSelStatus = s_axi_araddr == KPI_ADDR_EVENT_STATUS;
  wire rdSelMask = s_axi_araddr == KPI_ADDR_EVENT_MASK;
  wire rdMapped = rdSelCtrl | rdSelEnable | rdSelPolarity
                | rdSelStatus | rdSelMask;
  wire readsStatus = doRead & rdSelStatus;

  assign s_axi_arready = ~rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;

  // Acknowledge position stays zero
  always_comb begin
    ctrlWord = '0;
    ctrlWord[KPI_BIT_IRQ_FLAG] = irqFlag_q;
    ctrlWord[KPI_BIT_IRQ_ENABLE] = irqEnable_q;
    ctrlWord[KPI_BIT_DETECT_MODE] = detectMode_q;
  end

  assign enableWord = 32'(pinEnable_q);
  assign polarityWord = 32'(polarity_q);
  assign statusWord = 32'(eventStatus_q);
  assign maskWord = 32'(eventMask_q);
  // Unmapped addresses select nothing and read zero
  assign rdMux = ({32{rdSelCtrl}} & ctrlWord)
               | ({32{rdSelEnable}} & enableWord)
               | ({32{rdSelPolarity}} & polarityWord)
               | ({32{rdSelStatus}} & statusWord)
               | ({32{rdSelMask}} & maskWord);

  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      rValid_q <= 1'h0;
      rData_q <= '0;
      rResp_q <= KPI_RESP_OKAY;
    end else if (doRead) begin
      rValid_q <= 1'h1;
      rData_q <= rdMux;
      rResp_q <= rdMapped ? KPI_RESP_OKAY : KPI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_q <= 1'h0;
    end
  end

  // ------------------------------------------------------------
  // Sticky per-pin events
  // ------------------------------------------------------------
  // A read clears what it returned; a hit in the same cycle stays
  always_comb begin
    eventStatus_d = eventStatus_q;
    if (readsStatus) begin
      eventStatus_d = '0;
    end
    eventStatus_d = eventStatus_d | edgeHit
                  | (levelHit & {PIN_COUNT{detectMode_q}});
  end

  always_ff @(posedge refClk or posedge rst) begin
    if (rst) begin
      eventStatus_q <= '0;
    end else begin
      eventStatus_q <= eventStatus_d;
    end
  end


  // ------------------------------------------------------------
  // System interrupt
  // ------------------------------------------------------------
  // Masked per-pin events, apart from the pin request line
  assign irqOut = |(eventStatus_q & eventMask_q);

endmodule

// file: verif/kpi_checker.sv
`timescale 1ns/1ps
// ------
// Port checks
// ------
module kpi_checker #(
  parameter int PIN_COUNT = 8
) (
  input wire logic refClk,
  input wire logic rst,
  input wire logic [PIN_COUNT-1:0] pullEnable,
  input wire logic [PIN_COUNT-1:0] pullUpOn,
  input wire logic [PIN_COUNT-1:0] pullDownOn,
  input wire logic pinIrqRequest,
  input wire logic irqOut,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge refClk); endclocking
  default disable iff (rst);
  pull_split_a: assert property ((pullUpOn | pullDownOn) == pullEnable
    && (pullUpOn & pullDownOn) == '0) else $error("pull select bad");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  bresp_once_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("write response repeated");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready
    |-> ##[1:2] s_axi_rvalid) else $error("read response late");
  rresp_once_a: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read response repeated");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  rdata_upper_a: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  flag_clear_a: assert property ($fell(pinIrqRequest)
    |-> $rose(s_axi_bvalid)) else $error("request dropped unasked");
  irq_clear_a: assert property ($fell(irqOut)
    |-> s_axi_rvalid || s_axi_bvalid) else $error("irq dropped unasked");
endmodule

// file: verif/kpi_keypad_model.sv
`timescale 1ns/1ps
// ------
// Switches with pull resistors
// ------
module kpi_keypad_model (
  input wire logic refClk,
  input wire logic [7:0] keyClosed,
  input wire logic [7:0] keyLevel,
  input wire logic [7:0] pullUpOn,
  input wire logic [7:0] pullDownOn,
  output logic [7:0] pinIn
);
  // Floating pins toggle so an unpulled line never looks quiet
  logic [7:0] floatQ = 8'h5a;
  always @(posedge refClk) floatQ <= ~pinIn;
  assign pinIn = (keyClosed & keyLevel) | (~keyClosed
    & (pullUpOn | (~pullDownOn & floatQ)));
endmodule

// file: verif/keypad_pin_interrupt_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin failCount++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module keypad_pin_interrupt_test;
  import kpi_pkg::*;
  logic refClk = 0, rst = 1, pinIrqRequest, irqOut;
  logic [7:0] pinIn, pullUpOn, pullDownOn, pullEnable = 8'hff;
  logic [7:0] keyClosed = 8'hff, keyLevel = 8'hff, pinEn, bn, bm;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready = 0, flag = 0, irqEn = 0, mode = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int failCount = 0, checks = 0, cyc = 0, seed = 64576;
  kpi_keypad_pin_interrupt #(.PIN_COUNT(8)) kpi_keypad_pin_interrupt_inst (.*);
  kpi_keypad_model kpi_keypad_model_inst (.*);
  initial forever #4 refClk = ~refClk;
  always @(posedge refClk) begin
    cyc++;
    if (cyc == 60000) begin
      failCount++;
      wrapUp();
    end
  end
  task automatic wrapUp();
    if (failCount == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------
  // Bus master and model
  // ------
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    @(posedge refClk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge refClk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge refClk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge refClk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    rv = s_axi_rdata;
    `CHK("rresp", er, s_axi_rresp)
  endtask
  task automatic chkRd(input logic [7:0] a, input logic [31:0] e);
    rd(a, KPI_RESP_OKAY);
    `CHK("read", e, rv)
  endtask
  task automatic chkSc();
    chkRd(KPI_ADDR_STATUS_CONTROL, {28'h0, flag, 1'b0, irqEn, mode});
  endtask
  task automatic wSc(input logic [3:0] c);
    wr(KPI_ADDR_STATUS_CONTROL, {4'h0, c}, KPI_RESP_OKAY);
    mode = c[0];
    irqEn = c[1];
    // Level mode keeps the flag while a watched key is held
    if (c[2] && !(mode && (keyClosed & pinEn) != 0)) flag = 0;
  endtask
  task automatic settle();
    repeat (8) @(posedge refClk);
  endtask
  initial begin
    repeat (2) @(posedge refClk);
    rst <= 0;
    for (int i = 0; i < 5; i++) chkRd(8'(i * 4), 32'h0);
    rd(8'h14, KPI_RESP_SLVERR);
    `CHK("unmapped", 32'h0, rv)
    wr(8'h14, 8'hff, KPI_RESP_SLVERR);
    s_axi_wstrb <= 4'he;
    wr(KPI_ADDR_PIN_ENABLE, 8'hff, KPI_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    chkRd(KPI_ADDR_PIN_ENABLE, 32'h0);
    for (int i = 4; i > 0; i--) if (i != 3) begin
      v = $random(seed);
      pullEnable <= v[15:8];
      wr(8'(i * 4), v[7:0], KPI_RESP_OKAY);
      chkRd(8'(i * 4), {24'h0, v[7:0]});
    end
    rd(KPI_ADDR_EDGE_POLARITY, KPI_RESP_OKAY);
    `CHK("pullUp", pullEnable & ~rv[7:0], pullUpOn)
    `CHK("pullDown", pullEnable & rv[7:0], pullDownOn)
    pinEn = 0;
    wr(KPI_ADDR_PIN_ENABLE, 8'h0, KPI_RESP_OKAY);
    v = $random(seed);
    wSc(v[3:0] | 4'h8);
    chkSc();
    pullEnable <= 8'hff;
    for (int p = 0; p < 2; p++) for (int n = 0; n < 8; n++) begin
      bn = 8'h1 << n;
      bm = 8'h1 << ((n + 1) % 8);
      keyLevel <= {8{p[0]}};
      keyClosed <= bn | bm;
      wSc(4'h0);
      wr(KPI_ADDR_PIN_ENABLE, 8'h0, KPI_RESP_OKAY);
      wr(KPI_ADDR_EDGE_POLARITY, {8{p[0]}}, KPI_RESP_OKAY);
      pinEn = bn;
      wr(KPI_ADDR_PIN_ENABLE, bn, KPI_RESP_OKAY);
      wSc(4'h2);
      settle();
      chkSc();
      keyClosed <= bm;
      settle();
      chkSc();
      rd(KPI_ADDR_EVENT_STATUS, KPI_RESP_OKAY);
      wr(KPI_ADDR_EVENT_MASK, bn, KPI_RESP_OKAY);
      keyClosed <= bn | bm;
      settle();
      flag = 1;
      chkSc();
      `CHK("request", 1'b1, pinIrqRequest)
      `CHK("irqOut", 1'b1, irqOut)
      chkRd(KPI_ADDR_EVENT_STATUS, {24'h0, bn});
      `CHK("irqOut", 1'b0, irqOut)
      wSc(4'ha);
      chkSc();
      wSc(4'h6);
      chkSc();
      wSc(4'h3);
      settle();
      flag = 1;
      chkSc();
      wSc(4'h1);
      `CHK("request", 1'b0, pinIrqRequest)
      wSc(4'h5);
      chkSc();
      keyClosed <= 8'h0;
      settle();
      wSc(4'h5);
      chkSc();
    end
    wrapUp();
  end
endmodule
bind kpi_keypad_pin_interrupt kpi_checker #(.PIN_COUNT(PIN_COUNT))
  kpi_checker_inst (.*);
